// ### src/dpp_defines.vh
// Constants for the drive protection and process PID block.
// Assumes a 100 MHz clock; percentages in 0.1 % steps, times in 0.1 s steps.
`ifndef DPP_DEFINES_VH
`define DPP_DEFINES_VH

// Clock and time bases
`define DPP_CLK_HZ 100000000
`define DPP_MS_NS 1000000
`define DPP_CLK_NS 10
`define DPP_MS_CYCLES (`DPP_MS_NS / `DPP_CLK_NS)
`define DPP_PID_PERIOD_MS 2
`define DPP_TMR_TICK_MS 100

// Fixed-point scales
`define DPP_PCT_FULL 10'h3e8
`define DPP_GAIN_FULL 1000
`define DPP_P_SCALE 1000000
`define DPP_I_SCALE 5000
`define DPP_LL_PCT 19'h7
`define DPP_LL_DIV 19'h64
`define DPP_OVS_MAX 10'h1f4

// Selector codes
`define DPP_DIP_STOP 2'h2
`define DPP_ACT_COAST 2'h0
`define DPP_ACT_STOPMODE 2'h1
`define DPP_ACT_CONTINUE 2'h2

// Ramp step, timer saturation and timer indices
`define DPP_RAMP_STEP 16'h000a
`define DPP_TMR_SAT 10'h3ff
`define DPP_TMR_LL 0
`define DPP_TMR_OS 1
`define DPP_TMR_DEV 2

`endif

// ### src/dpp_drive_protect_pid.v
// Drive supervision (power dip, load loss, over-speed, speed deviation) and process PID.
// Assumes all inputs synchronous to clock_i; settings held stable by the parameter store.
// Contract
// - Dip action 2 with supply dip ramps output frequency down to standstill.
// - Enabled load loss below level longer than time drops frequency to 7% rated.
// - During load-loss fallback, normal current returns output to set frequency.
// - Load-loss enable defaults off; its other value turns detection on.
// - Vector mode speed above max plus margin too long raises over-speed fault.
// - Over-speed time of zero disables over-speed detection.
// - Vector mode speed off set frequency beyond margin too long raises deviation fault.
// - Deviation time of zero disables speed-deviation detection.
// - Over-speed margin is limited to 0.0 through 50.0 percent of maximum.
// - Setpoint source: digital, voltage 1, current, voltage 2, pulse, comm, multi-ref.
// - Setpoint is relative 0.0 to 100.0 percent; digital setpoint defaults to 50.0.
// - Feedback source: V1, I, V2, V1-I, pulse, comm, sum, maximum, minimum.
// - Feedback is a relative quantity from 0.0 to 100.0 percent.
// - Forward direction raises frequency when feedback is below setpoint.
// - Reverse direction lowers frequency when feedback is below setpoint.
// - Digital input with function 35 inverts PID direction while active.
// - Display shows setpoint or feedback scaled so 100 percent equals display range.
// - Gain 100.0 with full deviation gives a correction of maximum frequency.
// - Full deviation held one integral time integrates to maximum frequency; the code gets there in a tenth of that time.
// - The PID regulator updates its output every 2 ms.
// - Stop-mode faults warn, ramp to stop, then show the fault code.
`timescale 1ns/1ps
`include "dpp_defines.vh"

module dpp_drive_protect_pid #(
  parameter MS_CYCLES = `DPP_MS_CYCLES
) (
  input wire clock_i,
  input wire rstn_i,
  input wire run_i,
  input wire [15:0] set_freq_i,
  input wire [15:0] max_freq_i,
  input wire [15:0] rated_freq_i,
  input wire [1:0] power_dip_action_sel_i,
  input wire supply_dip_i,
  input wire load_loss_enable_i,
  input wire [9:0] out_current_pct_i,
  input wire [9:0] load_loss_level_i,
  input wire [9:0] load_loss_time_i,
  input wire closed_loop_vector_mode_i,
  input wire [15:0] speed_fb_i,
  input wire [9:0] overspeed_value_i,
  input wire [9:0] overspeed_time_i,
  input wire [9:0] speed_dev_value_i,
  input wire [9:0] speed_dev_time_i,
  input wire [1:0] overspeed_action_i,
  input wire [1:0] speed_dev_action_i,
  input wire fault_reset_i,
  input wire [2:0] pid_setpoint_source_i,
  input wire [9:0] pid_digital_setpoint_i,
  input wire [3:0] pid_feedback_source_i,
  input wire [9:0] voltage_input_1_i,
  input wire [9:0] current_input_i,
  input wire [9:0] voltage_input_2_i,
  input wire [9:0] pulse_input_i,
  input wire [9:0] comm_setpoint_i,
  input wire [9:0] comm_feedback_i,
  input wire [9:0] multi_ref_i,
  input wire pid_direction_i,
  input wire digital_input_pid_rev_i,
  input wire [15:0] pid_display_range_i,
  input wire [9:0] prop_gain_set1_i,
  input wire [9:0] integral_time_set1_i,
  output wire [15:0] freq_ref_o,
  output wire load_loss_active_o,
  output wire overspeed_fault_o,
  output wire speed_deviation_fault_o,
  output wire warning_o,
  output wire signed [16:0] pid_out_o,
  output wire [9:0] pid_setpoint_o,
  output wire [9:0] pid_feedback_o,
  output wire [15:0] pid_setpoint_disp_o,
  output wire [15:0] pid_feedback_disp_o
);

  localparam ST_RUN = 2'h0;
  localparam ST_LOADLOSS = 2'h1;
  localparam ST_RAMPSTOP = 2'h2;
  localparam ST_HALT = 2'h3;

  function [9:0] pct_clip;
    input [10:0] v;
    begin
      pct_clip = (v > `DPP_PCT_FULL) ? 10'h3e8 : v[9:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and time bases
  reg [1:0] rst_sync_r;
  wire rst_n = rst_sync_r[1];
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  reg [31:0] ms_cnt_r;
  reg [6:0] tick100_cnt_r;
  reg pid_phase_r;
  wire ms_tick = (ms_cnt_r == MS_CYCLES - 1);
  wire tmr_tick = ms_tick && (tick100_cnt_r == `DPP_TMR_TICK_MS - 1);
  wire pid_tick = ms_tick && pid_phase_r;
  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_r <= 32'h0;
      tick100_cnt_r <= 7'h0;
      pid_phase_r <= 1'b0;
    end else begin
      ms_cnt_r <= ms_tick ? 32'h0 : ms_cnt_r + 32'h1;
      if (ms_tick) begin
        pid_phase_r <= ~pid_phase_r;
        tick100_cnt_r <= tmr_tick ? 7'h0 : tick100_cnt_r + 7'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Detection conditions
  reg [15:0] freq_r;
  wire [9:0] ovs_pct = (overspeed_value_i > `DPP_OVS_MAX) ? `DPP_OVS_MAX : overspeed_value_i;
  wire [9:0] dev_pct = (speed_dev_value_i > `DPP_OVS_MAX) ? `DPP_OVS_MAX : speed_dev_value_i;
  wire [25:0] ovs_prod = max_freq_i * ovs_pct / `DPP_PCT_FULL;
  wire [25:0] dev_prod = max_freq_i * dev_pct / `DPP_PCT_FULL;
  wire [16:0] ovs_lim = {1'b0, max_freq_i} + ovs_prod[16:0];
  wire [16:0] dev_lim = dev_prod[16:0];
  wire [16:0] spd_diff = (speed_fb_i > set_freq_i) ? {1'b0, speed_fb_i - set_freq_i} :
                         {1'b0, set_freq_i - speed_fb_i};
  wire [2:0] cond;
  assign cond[`DPP_TMR_LL] = load_loss_enable_i && run_i &&
                             (out_current_pct_i < load_loss_level_i);
  assign cond[`DPP_TMR_OS] = closed_loop_vector_mode_i && (overspeed_time_i != 10'h0) &&
                             ({1'b0, speed_fb_i} > ovs_lim);
  assign cond[`DPP_TMR_DEV] = closed_loop_vector_mode_i && run_i &&
                              (speed_dev_time_i != 10'h0) && (spd_diff > dev_lim);
  wire [29:0] tmr_lim = {speed_dev_time_i, overspeed_time_i, load_loss_time_i};

  reg [9:0] tmr_cnt_r [0:2];
  wire [2:0] hit;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_tmr
      always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
          tmr_cnt_r[g] <= 10'h0;
        end else if (!cond[g]) begin
          tmr_cnt_r[g] <= 10'h0;
        end else if (tmr_tick && tmr_cnt_r[g] != `DPP_TMR_SAT) begin
          tmr_cnt_r[g] <= tmr_cnt_r[g] + 10'h1;
        end
      end
      assign hit[g] = cond[g] && (tmr_cnt_r[g] > tmr_lim[g*10 +: 10]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Fault latches; a new detection wins over a reset in the same cycle
  reg os_flag_r;
  reg dev_flag_r;
  reg dip_stop_r;
  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      os_flag_r <= 1'b0;
      dev_flag_r <= 1'b0;
      dip_stop_r <= 1'b0;
    end else begin
      os_flag_r <= hit[`DPP_TMR_OS] | (os_flag_r & ~fault_reset_i);
      dev_flag_r <= hit[`DPP_TMR_DEV] | (dev_flag_r & ~fault_reset_i);
      if (run_i && supply_dip_i && power_dip_action_sel_i == `DPP_DIP_STOP) begin
        dip_stop_r <= 1'b1;
      end else if (!run_i) begin
        dip_stop_r <= 1'b0;
      end
    end
  end

  wire os_coast = os_flag_r && overspeed_action_i == `DPP_ACT_COAST;
  wire dev_coast = dev_flag_r && speed_dev_action_i == `DPP_ACT_COAST;
  wire os_stopm = os_flag_r && overspeed_action_i == `DPP_ACT_STOPMODE;
  wire dev_stopm = dev_flag_r && speed_dev_action_i == `DPP_ACT_STOPMODE;
  wire coast = os_coast | dev_coast;
  wire stop_req = dip_stop_r | os_stopm | dev_stopm;

  ////////////////////////////////////////////////////////////////////////////
  // Reference state machine and ramp
  reg [1:0] st_r;
  reg [1:0] st_nxt;
  reg [15:0] target;
  wire [18:0] ll_prod = rated_freq_i * `DPP_LL_PCT;
  wire [18:0] ll_freq = ll_prod / `DPP_LL_DIV;
  always @* begin
    st_nxt = st_r;
    target = 16'h0;
    case (st_r)
      ST_RUN: begin
        target = run_i ? set_freq_i : 16'h0;
        if (stop_req) begin
          st_nxt = ST_RAMPSTOP;
        end else if (hit[`DPP_TMR_LL]) begin
          st_nxt = ST_LOADLOSS;
        end
      end
      ST_LOADLOSS: begin
        target = ll_freq[15:0];
        if (stop_req) begin
          st_nxt = ST_RAMPSTOP;
        end else if (!cond[`DPP_TMR_LL]) begin
          st_nxt = ST_RUN;
        end
      end
      ST_RAMPSTOP: begin
        target = 16'h0;
        if (freq_r == 16'h0) begin
          st_nxt = ST_HALT;
        end
      end
      ST_HALT: begin
        if (!run_i && !os_flag_r && !dev_flag_r) begin
          st_nxt = ST_RUN;
        end
      end
      default: begin
        st_nxt = ST_RUN;
      end
    endcase
  end

  // Fixed ramp rate per millisecond; the drive's own accel and decel times sit elsewhere
  reg [15:0] freq_nxt;
  always @* begin
    freq_nxt = freq_r;
    if (coast) begin
      freq_nxt = 16'h0;
    end else if (ms_tick && freq_r < target) begin
      freq_nxt = (target - freq_r > `DPP_RAMP_STEP) ? freq_r + `DPP_RAMP_STEP : target;
    end else if (ms_tick && freq_r > target) begin
      freq_nxt = (freq_r - target > `DPP_RAMP_STEP) ? freq_r - `DPP_RAMP_STEP : target;
    end
  end

  reg ll_act_r;
  reg os_show_r;
  reg dev_show_r;
  reg warn_r;
  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_RUN;
      freq_r <= 16'h0;
      ll_act_r <= 1'b0;
      os_show_r <= 1'b0;
      dev_show_r <= 1'b0;
      warn_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      freq_r <= freq_nxt;
      ll_act_r <= (st_nxt == ST_LOADLOSS);
      // Stop-mode faults show the code only once the output has reached zero
      os_show_r <= os_coast | (os_stopm && freq_r == 16'h0);
      dev_show_r <= dev_coast | (dev_stopm && freq_r == 16'h0);
      warn_r <= ((os_flag_r & ~os_coast) & ~(os_stopm && freq_r == 16'h0)) |
                ((dev_flag_r & ~dev_coast) & ~(dev_stopm && freq_r == 16'h0));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PID source selection
  reg [9:0] sp_sel;
  reg [9:0] fb_sel;
  wire [10:0] fb_sum = {1'b0, voltage_input_1_i} + {1'b0, current_input_i};
  wire v1_ge = voltage_input_1_i >= current_input_i;
  always @* begin
    case (pid_setpoint_source_i)
      3'h0: sp_sel = pid_digital_setpoint_i;
      3'h1: sp_sel = voltage_input_1_i;
      3'h2: sp_sel = current_input_i;
      3'h3: sp_sel = voltage_input_2_i;
      3'h4: sp_sel = pulse_input_i;
      3'h5: sp_sel = comm_setpoint_i;
      3'h6: sp_sel = multi_ref_i;
      default: sp_sel = pid_digital_setpoint_i;
    endcase
    case (pid_feedback_source_i)
      4'h0: fb_sel = voltage_input_1_i;
      4'h1: fb_sel = current_input_i;
      4'h2: fb_sel = voltage_input_2_i;
      4'h3: fb_sel = v1_ge ? voltage_input_1_i - current_input_i : 10'h0;
      4'h4: fb_sel = pulse_input_i;
      4'h5: fb_sel = comm_feedback_i;
      4'h6: fb_sel = pct_clip(fb_sum);
      4'h7: fb_sel = v1_ge ? voltage_input_1_i : current_input_i;
      4'h8: fb_sel = v1_ge ? current_input_i : voltage_input_1_i;
      default: fb_sel = voltage_input_1_i;
    endcase
  end
  wire [9:0] sp_pct = pct_clip({1'b0, sp_sel});
  wire [9:0] fb_pct = pct_clip({1'b0, fb_sel});

  ////////////////////////////////////////////////////////////////////////////
  // PID arithmetic
  wire dir_rev = pid_direction_i ^ digital_input_pid_rev_i;
  wire signed [10:0] err_fwd = $signed({1'b0, sp_pct}) - $signed({1'b0, fb_pct});
  wire signed [10:0] err = dir_rev ? -err_fwd : err_fwd;
  wire signed [17:0] fmax_s = $signed({2'b0, max_freq_i});
  wire signed [47:0] p_num = err * $signed({1'b0, prop_gain_set1_i}) * fmax_s;
  wire signed [47:0] p_term = p_num / `DPP_P_SCALE;
  // Integral kept unscaled so no resolution is lost between 2 ms steps
  wire [9:0] ti = (integral_time_set1_i == 10'h0) ? 10'h1 : integral_time_set1_i;
  wire signed [47:0] i_den = $signed({25'h0, ti, 13'h0}) / 48'sd8192 * `DPP_I_SCALE;
  wire signed [47:0] i_lim = fmax_s * i_den;
  reg signed [47:0] i_acc_r;
  wire signed [47:0] i_sum = i_acc_r + err * fmax_s;
  wire signed [47:0] i_clip = (i_sum > i_lim) ? i_lim : ((i_sum < -i_lim) ? -i_lim : i_sum);
  wire signed [47:0] i_term = i_acc_r / i_den;
  wire signed [47:0] pi_sum = p_term + i_term;
  wire signed [47:0] fmax_w = fmax_s;
  wire signed [47:0] pi_clip = (pi_sum > fmax_w) ? fmax_w :
                               ((pi_sum < -fmax_w) ? -fmax_w : pi_sum);

  wire [25:0] sp_disp_prod = sp_pct * pid_display_range_i;
  wire [25:0] fb_disp_prod = fb_pct * pid_display_range_i;
  wire [25:0] sp_disp = sp_disp_prod / `DPP_PCT_FULL;
  wire [25:0] fb_disp = fb_disp_prod / `DPP_PCT_FULL;

  reg signed [16:0] pid_out_r;
  reg [9:0] sp_r;
  reg [9:0] fb_r;
  reg [15:0] sp_disp_r;
  reg [15:0] fb_disp_r;
  always @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      i_acc_r <= 48'sh0;
      pid_out_r <= 17'sh0;
      sp_r <= 10'h0;
      fb_r <= 10'h0;
      sp_disp_r <= 16'h0;
      fb_disp_r <= 16'h0;
    end else begin
      sp_r <= sp_pct;
      fb_r <= fb_pct;
      sp_disp_r <= sp_disp[15:0];
      fb_disp_r <= fb_disp[15:0];
      if (!run_i) begin
        i_acc_r <= 48'sh0;
        pid_out_r <= 17'sh0;
      end else if (pid_tick) begin
        i_acc_r <= i_clip;
        pid_out_r <= pi_clip[16:0];
      end
    end
  end

  assign freq_ref_o = freq_r;
  assign load_loss_active_o = ll_act_r;
  assign overspeed_fault_o = os_show_r;
  assign speed_deviation_fault_o = dev_show_r;
  assign warning_o = warn_r;
  assign pid_out_o = pid_out_r;
  assign pid_setpoint_o = sp_r;
  assign pid_feedback_o = fb_r;
  assign pid_setpoint_disp_o = sp_disp_r;
  assign pid_feedback_disp_o = fb_disp_r;

endmodule

// ### tb/dpp_drive_protect_pid_properties.sv
// Port checker for the protection and PID block.
// Assumes settings held steady while a detection runs.
`timescale 1ns/1ps
module dpp_checker #(
  parameter int MS_CYCLES = 10
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic run_i,
  input wire logic [1:0] power_dip_action_sel_i,
  input wire logic supply_dip_i,
  input wire logic load_loss_enable_i,
  input wire logic [9:0] out_current_pct_i,
  input wire logic [9:0] load_loss_level_i,
  input wire logic [9:0] load_loss_time_i,
  input wire logic closed_loop_vector_mode_i,
  input wire logic [9:0] overspeed_time_i,
  input wire logic [9:0] speed_dev_time_i,
  input wire logic [15:0] max_freq_i,
  input wire logic [15:0] pid_display_range_i,
  input wire logic [15:0] freq_ref_o,
  input wire logic load_loss_active_o,
  input wire logic overspeed_fault_o,
  input wire logic speed_deviation_fault_o,
  input wire logic signed [16:0] pid_out_o,
  input wire logic [9:0] pid_setpoint_o,
  input wire logic [15:0] pid_setpoint_disp_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////
  // Low-current run length; design tick phase only makes it later
  logic [31:0] low_cnt_r;
  always @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i)
      low_cnt_r <= '0;
    else if (load_loss_enable_i && out_current_pct_i < load_loss_level_i)
      low_cnt_r <= low_cnt_r + 1;
    else
      low_cnt_r <= '0;
  end
  a_ll_not_early: assert property ($rose(load_loss_active_o) |->
    low_cnt_r >= load_loss_time_i * MS_CYCLES * 100) else $error("load loss too early");
  a_ll_recover: assert property ((load_loss_active_o &&
    out_current_pct_i >= load_loss_level_i) |-> ##[1:4] !load_loss_active_o)
    else $error("load loss held after recovery");
  a_ramp_up_step: assert property ((freq_ref_o > $past(freq_ref_o)) |->
    freq_ref_o - $past(freq_ref_o) <= 16'h000a) else $error("ramp step too big");
  a_dip_no_rise: assert property (($past(supply_dip_i, 3) && $past(run_i, 3) &&
    power_dip_action_sel_i == 2'h2) |-> freq_ref_o <= $past(freq_ref_o))
    else $error("frequency rose in dip stop");
  a_os_gated: assert property ($rose(overspeed_fault_o) |->
    overspeed_time_i != 10'h0 && closed_loop_vector_mode_i) else $error("over-speed ungated");
  a_dev_gated: assert property ($rose(speed_deviation_fault_o) |->
    speed_dev_time_i != 10'h0 && closed_loop_vector_mode_i) else $error("deviation ungated");
  a_pid_clip: assert property (pid_out_o <= $signed({1'b0, max_freq_i}) &&
    pid_out_o >= -$signed({1'b0, max_freq_i})) else $error("pid output beyond max");
  a_pid_period: assert property (($changed(pid_out_o) && run_i) |=>
    ($stable(pid_out_o) || !run_i)[*8]) else $error("pid updated too often");
  a_disp_scale: assert property (($stable(pid_setpoint_o) &&
    $stable(pid_display_range_i))[*3] |-> pid_setpoint_disp_o ==
    16'((32'(pid_setpoint_o) * pid_display_range_i) / 1000)) else $error("display scale");
  c_os: cover property ($rose(overspeed_fault_o));
  c_dev: cover property ($rose(speed_deviation_fault_o));
  c_ll: cover property ($rose(load_loss_active_o));
endmodule
bind dpp_drive_protect_pid dpp_checker #(.MS_CYCLES(MS_CYCLES)) dpp_checker_inst (
  .clock_i, .rstn_i, .run_i, .power_dip_action_sel_i, .supply_dip_i, .load_loss_enable_i,
  .out_current_pct_i, .load_loss_level_i, .load_loss_time_i, .closed_loop_vector_mode_i,
  .overspeed_time_i, .speed_dev_time_i, .max_freq_i, .pid_display_range_i, .freq_ref_o,
  .load_loss_active_o, .overspeed_fault_o, .speed_deviation_fault_o, .pid_out_o,
  .pid_setpoint_o, .pid_setpoint_disp_o);

// ### tb/dpp_drive_protect_pid_tb.sv
// Self-checking bench for the protection and PID block.
// Assumes MS_CYCLES of 10: 100 ms tick is 1000 cycles, PID step 20.
`timescale 1ns/1ps
module dpp_drive_protect_pid_tb;
  logic clock_i, rstn_i, run_i, supply_dip_i, load_loss_enable_i, closed_loop_vector_mode_i;
  logic fault_reset_i, pid_direction_i, digital_input_pid_rev_i, load_on;
  logic [1:0] power_dip_action_sel_i, overspeed_action_i, speed_dev_action_i;
  logic [2:0] pid_setpoint_source_i;
  logic [3:0] pid_feedback_source_i;
  logic [15:0] set_freq_i, max_freq_i, rated_freq_i, speed_fb_i, pid_display_range_i, spd_off;
  logic [9:0] out_current_pct_i, load_loss_level_i, load_loss_time_i, overspeed_value_i;
  logic [9:0] overspeed_time_i, speed_dev_value_i, speed_dev_time_i, pid_digital_setpoint_i;
  logic [9:0] voltage_input_1_i, current_input_i, voltage_input_2_i, pulse_input_i;
  logic [9:0] comm_setpoint_i, comm_feedback_i, multi_ref_i, prop_gain_set1_i;
  logic [9:0] integral_time_set1_i, pid_setpoint_o, pid_feedback_o;
  logic [15:0] freq_ref_o, pid_setpoint_disp_o, pid_feedback_disp_o;
  logic load_loss_active_o, overspeed_fault_o, speed_deviation_fault_o, warning_o;
  logic signed [16:0] pid_out_o;
  int errors, compares, cyc;
  int fb_exp[9] = '{110, 120, 130, 0, 140, 170, 230, 120, 110};
  ////////////////////////////////////////
  dpp_drive_protect_pid #(.MS_CYCLES(10)) dpp_drive_protect_pid_inst (
    .clock_i, .rstn_i, .run_i, .set_freq_i, .max_freq_i, .rated_freq_i,
    .power_dip_action_sel_i, .supply_dip_i, .load_loss_enable_i, .out_current_pct_i,
    .load_loss_level_i, .load_loss_time_i, .closed_loop_vector_mode_i, .speed_fb_i,
    .overspeed_value_i, .overspeed_time_i, .speed_dev_value_i, .speed_dev_time_i,
    .overspeed_action_i, .speed_dev_action_i, .fault_reset_i, .pid_setpoint_source_i,
    .pid_digital_setpoint_i, .pid_feedback_source_i, .voltage_input_1_i, .current_input_i,
    .voltage_input_2_i, .pulse_input_i, .comm_setpoint_i, .comm_feedback_i, .multi_ref_i,
    .pid_direction_i, .digital_input_pid_rev_i, .pid_display_range_i, .prop_gain_set1_i,
    .integral_time_set1_i, .freq_ref_o, .load_loss_active_o, .overspeed_fault_o,
    .speed_deviation_fault_o, .warning_o, .pid_out_o, .pid_setpoint_o, .pid_feedback_o,
    .pid_setpoint_disp_o, .pid_feedback_disp_o);
  dpp_motor_model dpp_motor_model_inst (.freq_ref_i(freq_ref_o), .speed_offset_i(spd_off),
    .load_on_i(load_on), .speed_fb_o(speed_fb_i), .out_current_pct_o(out_current_pct_i));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // Ceiling sits well above the roughly 21k cycles the tests need
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic wait_for(ref logic s, input int lim);
    int k = 0;
    while (s !== 1'b1 && k < lim) begin
      @(negedge clock_i);
      k++;
    end
  endtask
  // Faults stay latched while detection holds, so clear the cause first
  task automatic idle();
    run_i = 1'b0;
    spd_off = 16'h0;
    fault_reset_i = 1'b1;
    tick(3);
    fault_reset_i = 1'b0;
    tick(3);
  endtask
  task automatic end_sim();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    {rstn_i, run_i, supply_dip_i, load_loss_enable_i, closed_loop_vector_mode_i} = '0;
    {fault_reset_i, pid_direction_i, digital_input_pid_rev_i, load_on} = '0;
    {power_dip_action_sel_i, overspeed_action_i, pid_setpoint_source_i} = '0;
    {pid_feedback_source_i, overspeed_time_i, speed_dev_time_i, spd_off} = '0;
    errors = 0;
    compares = 0;
    cyc = 0;
    speed_dev_action_i = 2'h1;
    set_freq_i = 16'h03e8;
    max_freq_i = 16'h1388;
    rated_freq_i = 16'h1388;
    pid_display_range_i = 16'h03e8;
    load_loss_level_i = 10'h064;
    load_loss_time_i = 10'h001;
    {overspeed_value_i, speed_dev_value_i} = {10'h0c8, 10'h0c8};
    {pid_digital_setpoint_i, prop_gain_set1_i, integral_time_set1_i} = {3{10'h0}};
    pid_digital_setpoint_i = 10'h1f4;
    {voltage_input_1_i, current_input_i, voltage_input_2_i} = {10'h06e, 10'h078, 10'h082};
    {pulse_input_i, comm_setpoint_i, multi_ref_i} = {10'h08c, 10'h096, 10'h0a0};
    comm_feedback_i = 10'h0aa;
    tick(5);
    rstn_i = 1'b1;
    tick(4);
    for (int s = 0; s < 8; s++) begin
      pid_setpoint_source_i = 3'(s);
      tick(3);
      chk("setpoint", pid_setpoint_o, (s == 0 || s == 7) ? 500 : 100 + s * 10);
    end
    for (int s = 0; s < 9; s++) begin
      pid_feedback_source_i = 4'(s);
      tick(3);
      chk("feedback", pid_feedback_o, fb_exp[s]);
    end
    {pid_setpoint_source_i, pid_feedback_source_i} = '0;
    pid_display_range_i = 16'h07d0;
    pid_digital_setpoint_i = 10'h3e8;
    tick(4);
    chk("sp_disp", pid_setpoint_disp_o, 2000);
    chk("fb_disp", pid_feedback_disp_o, 220);
    $display("test selection done");
    {pid_digital_setpoint_i, voltage_input_1_i} = {10'h320, 10'h0c8};
    {prop_gain_set1_i, integral_time_set1_i} = {10'h0c8, 10'h3e8};
    for (int d = 0; d < 3; d++) begin
      pid_direction_i = (d != 0);
      digital_input_pid_rev_i = (d == 2);
      run_i = 1'b1;
      tick(60);
      chk("pid_sign", pid_out_o[16], d == 1);
      run_i = 1'b0;
      tick(25);
      chk("pid_idle", pid_out_o, 0);
    end
    {pid_direction_i, digital_input_pid_rev_i} = '0;
    {pid_digital_setpoint_i, voltage_input_1_i, prop_gain_set1_i} = {10'h3e8, 10'h0, 10'h3e8};
    run_i = 1'b1;
    tick(60);
    chk("pid_full_p", pid_out_o, 5000);
    idle();
    {prop_gain_set1_i, integral_time_set1_i} = {10'h0, 10'h001};
    run_i = 1'b1;
    tick(60);
    chk("pid_i_part", pid_out_o > 17'sd0 && pid_out_o < 17'sd5000, 1);
    tick(140);
    chk("pid_i_full", pid_out_o, 5000);
    idle();
    $display("test pid done");
    run_i = 1'b1;
    tick(3000);
    chk("ll_off", load_loss_active_o, 0);
    load_loss_enable_i = 1'b1;
    wait_for(load_loss_active_o, 2500);
    chk("ll_on", load_loss_active_o, 1);
    tick(800);
    chk("ll_freq", freq_ref_o, 350);
    load_on = 1'b1;
    tick(800);
    chk("ll_back", {load_loss_active_o, freq_ref_o}, 1000);
    // Short low-current spells never span two timer ticks once the count restarts
    for (int r = 0; r < 3; r++) begin
      load_on = 1'b0;
      tick(900);
      load_on = 1'b1;
      tick(2);
    end
    chk("ll_restart", load_loss_active_o, 0);
    power_dip_action_sel_i = 2'h2;
    supply_dip_i = 1'b1;
    tick(1200);
    chk("dip_freq", freq_ref_o, 0);
    supply_dip_i = 1'b0;
    tick(50);
    chk("dip_halt", freq_ref_o, 0);
    idle();
    power_dip_action_sel_i = 2'h0;
    $display("test load and dip done");
    {closed_loop_vector_mode_i, run_i, spd_off} = {1'b1, 1'b1, 16'h157c};
    tick(3000);
    chk("faults_off", {overspeed_fault_o, speed_deviation_fault_o}, 0);
    {overspeed_value_i, overspeed_time_i} = {10'h2bc, 10'h001};
    tick(3000);
    chk("os_clamp", overspeed_fault_o, 0);
    // Speed 8000 trips only if the 70 percent margin is held at 50 percent
    spd_off = 16'h1b58;
    wait_for(overspeed_fault_o, 2500);
    chk("os_fault", overspeed_fault_o, 1);
    tick(2);
    chk("os_coast", freq_ref_o, 0);
    overspeed_time_i = 10'h0;
    idle();
    chk("os_clear", overspeed_fault_o, 0);
    {speed_dev_time_i, spd_off, run_i} = {10'h001, 16'h05dc, 1'b1};
    wait_for(warning_o, 3500);
    chk("dev_warn", {warning_o, speed_deviation_fault_o}, 2);
    wait_for(speed_deviation_fault_o, 1500);
    chk("dev_fault", speed_deviation_fault_o, 1);
    chk("dev_stop", freq_ref_o, 0);
    $display("test speed faults done");
    end_sim();
  end
endmodule

// ### tb/dpp_motor_model.sv
// Motor and process sensor stand-in for the protection block.
// Assumes speed follows the reference plus a bench offset.
`timescale 1ns/1ps
module dpp_motor_model (
  input wire logic [15:0] freq_ref_i,
  input wire logic [15:0] speed_offset_i,
  input wire logic load_on_i,
  output logic [15:0] speed_fb_o,
  output logic [9:0] out_current_pct_o
);
  // Offset lets the bench force over-speed or deviation
  assign speed_fb_o = freq_ref_i + speed_offset_i;
  // Light load sits well under the default detection level
  assign out_current_pct_o = load_on_i ? 10'h190 : 10'h01e;
endmodule
